/* hw/split_timer_map.svh */
// Purpose: Register addresses, field positions and reset values of the split timer.
// Assumes: Byte-wide special-function-register bus, one timer instance.
// Notes: Definitions only; included by bare name.
`ifndef SPLIT_TIMER_MAP_SVH
`define SPLIT_TIMER_MAP_SVH

// ==========================================================================
// Register addresses
`define TIMER_CONTROL_ADDR 8'hC8
`define TIMER_CLOCK_SELECT_ADDR 8'hC9
`define LOW_RELOAD_ADDR 8'hCA
`define HIGH_RELOAD_ADDR 8'hCB
`define LOW_COUNT_ADDR 8'hCC
`define HIGH_COUNT_ADDR 8'hCD

// ==========================================================================
// Control register fields
`define HIGH_HALF_FLAG_BIT 7
`define LOW_HALF_FLAG_BIT 6
`define LOW_HALF_IRQ_ENABLE_BIT 5
`define SPLIT_ENABLE_BIT 4
`define HIGH_CAPTURE_ENABLE_BIT 3
`define LOW_CAPTURE_ENABLE_BIT 2
`define HIGH_HALF_RUN_BIT 1
`define LOW_HALF_RUN_BIT 0

// ==========================================================================
// Clock select fields, two bits each
`define SECOND_LOW_CLOCK_SELECT_POS 0
`define SECOND_HIGH_CLOCK_SELECT_POS 2
`define THIRD_LOW_CLOCK_SELECT_POS 4
`define THIRD_HIGH_CLOCK_SELECT_POS 6

// ==========================================================================
// Reset values and timing
`define TIMER_CONTROL_RESET 8'h00
`define TIMER_CLOCK_SELECT_RESET 8'h00
`define SYS_DIVIDE_RATIO 12
`define SYS_DIVIDE_LAST 4'hB

`endif

/* hw/split_timer_pkg.sv */
// Purpose: Shared types of the split timer.
// Assumes: Encodings follow the clock select and edge fields.
// Notes: Never imported; referenced with the package scope.
package split_timer_pkg;

   // ==========================================================================
   // Count clock sources of one half
   typedef enum logic [1:0] {
      CLK_SYS,
      CLK_SYS_DIV12,
      CLK_RTC_TICK,
      CLK_RTC_PULSE
   } clk_src_t;

   // ==========================================================================
   // Capture edge programming of the external line
   typedef enum logic [1:0] {
      EDGE_RISE,
      EDGE_FALL,
      EDGE_BOTH
   } edge_mode_t;

   // ==========================================================================
   // Top-level state
   typedef struct packed {
      logic pin_meta;
      logic pin_sync;
      logic pin_prev;
      logic [3:0] div_count;
      logic [7:0] control;
      logic [7:0] clock_select;
      logic [7:0] rdata;
      logic irq;
      logic capture_irq;
      logic [3:0] third_select;
   } top_state_t;

endpackage

/* hw/half_if.sv */
// Purpose: Bundle between the timer core and one 8-bit half.
// Assumes: Single clock domain.
// Notes: Strobes are one-cycle pulses.
`timescale 1ns/1ps

interface half_if #(parameter int WIDTH = 8);
   logic tick;
   logic run;
   logic split;
   logic cap_mode;
   logic cap_evt;
   logic count_wr;
   logic reload_wr;
   logic [WIDTH-1:0] wdata;
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] reload;
   logic flag_set;

   modport core (output tick, run, split, cap_mode, cap_evt, count_wr, reload_wr, wdata,
                 input count, reload, flag_set);
   modport half (input tick, run, split, cap_mode, cap_evt, count_wr, reload_wr, wdata,
                 output count, reload, flag_set);
endinterface // half_if

/* hw/timer_half.sv */
// Purpose: One 8-bit half: auto-reload timer or free-running capture counter.
// Assumes: Tick is a one-cycle enable already selected by the core.
// Notes: Software count write beats a tick; a capture beats a reload write.
`timescale 1ns/1ps

module timer_half #(
   parameter int WIDTH = 8
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   half_if.half bus
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic [WIDTH-1:0] reload;
   } half_state_t;

   half_state_t state_reg;
   half_state_t state_next;
   logic counting;
   logic wrap;
   logic capture;

   // ==========================================================================
   // Count, wrap and capture
   always_comb begin
      state_next = state_reg;
      counting = bus.split && bus.run && bus.tick;
      wrap = counting && (state_reg.count == {WIDTH{1'b1}});
      capture = bus.split && bus.cap_mode && bus.cap_evt;
      if (bus.count_wr) begin
         state_next.count = bus.wdata;
      end else if (wrap && !bus.cap_mode) begin
         state_next.count = state_reg.reload;
      end else if (counting) begin
         state_next.count = state_reg.count + 1'b1;
      end
      if (capture) begin
         state_next.reload = state_reg.count;
      end else if (bus.reload_wr) begin
         state_next.reload = bus.wdata;
      end
   end

   // Overflow flags in timer function, capture flags in capture function
   assign bus.flag_set = bus.cap_mode ? capture : wrap;
   assign bus.count = state_reg.count;
   assign bus.reload = state_reg.reload;

   // State register
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule // timer_half

/* hw/split_timer.sv */
// Purpose: Split-mode pair of 8-bit timer halves with shared capture and interrupt.
// Assumes: rtc_tick_in and rtc_pulse_in are one-cycle strobes on clock_in.
// Notes: Wide 16-bit operation is not built; halves hold while split is clear.
// Operation
// - Split enable runs two independent 8-bit halves
// - Halves share only capture input and interrupt
// - Both capture enables clear: two reload timers
// - Timer half wraps, reloads, sets its flag
// - High timer-half overflow requests an interrupt; low only with its enable
// - Capture half counts freely, wraps without reload
// - Capture copies count byte into reload byte
// - Shared capture sets both flags when both capture enables are set
// - Stopped capture half still captures and flags
// - Mixed capture enables give timer plus capture
// - Only low flag has a local enable
// - Clock select: sys, sys/12, tick, pulse
// - Clock select register holds four 2-bit fields
// - Bit-addressable control register, reset zero
// - Capture halves count on own clocks
// - Capture event also raises external interrupt
// - Request is high flag or enabled low flag
// - Hardware never clears flags; software writes them
// - Capture is programmed edge of external line
// - Run bit enables its own half
`timescale 1ns/1ps
`include "split_timer_map.svh"

module split_timer #(
   parameter int WIDTH = 8
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_bit_wr_in,
   input wire logic [2:0] sfr_bit_sel_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_rd_in,
   input wire logic capture_pin_in,
   input wire logic [1:0] capture_edge_in,
   input wire logic rtc_tick_in,
   input wire logic rtc_pulse_in,
   output logic [7:0] sfr_rdata_out,
   output logic timer_irq_out,
   output logic capture_irq_out,
   output logic [3:0] third_clock_select_out
);

   split_timer_pkg::top_state_t state_reg;
   split_timer_pkg::top_state_t state_next;
   logic div_tick;
   logic cap_evt;
   logic [7:0] wr_mask;
   logic [7:0] wr_val;
   logic [1:0] flag_set;

   half_if #(.WIDTH(WIDTH)) hif [2] ();

   // ==========================================================================
   // Count clock selection
   function automatic logic pick_tick(input logic [1:0] sel, input logic div,
                                      input logic tick, input logic pulse);
      logic result;
      result = 1'b0;
      unique case (split_timer_pkg::clk_src_t'(sel))
         split_timer_pkg::CLK_SYS: result = 1'b1;
         split_timer_pkg::CLK_SYS_DIV12: result = div;
         split_timer_pkg::CLK_RTC_TICK: result = tick;
         split_timer_pkg::CLK_RTC_PULSE: result = pulse;
      endcase
      return result;
   endfunction

   // Capture edge detection on the synchronised line
   function automatic logic edge_hit(input logic [1:0] mode, input logic now,
                                     input logic prev);
      logic result;
      result = 1'b0;
      unique case (split_timer_pkg::edge_mode_t'(mode))
         split_timer_pkg::EDGE_RISE: result = now && !prev;
         split_timer_pkg::EDGE_FALL: result = !now && prev;
         split_timer_pkg::EDGE_BOTH: result = now ^ prev;
         default: result = 1'b0;
      endcase
      return result;
   endfunction

   // Divide by twelve strobe and capture event
   assign div_tick = (state_reg.div_count == `SYS_DIVIDE_LAST);
   assign cap_evt = edge_hit(capture_edge_in, state_reg.pin_sync, state_reg.pin_prev);

   // ==========================================================================
   // Halves: index 0 low, index 1 high
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_half
         localparam int SEL_POS = (gi == 0) ? `SECOND_LOW_CLOCK_SELECT_POS :
                                              `SECOND_HIGH_CLOCK_SELECT_POS;
         localparam int CAP_BIT = (gi == 0) ? `LOW_CAPTURE_ENABLE_BIT :
                                              `HIGH_CAPTURE_ENABLE_BIT;
         localparam int RUN_BIT = (gi == 0) ? `LOW_HALF_RUN_BIT : `HIGH_HALF_RUN_BIT;
         localparam logic [7:0] CNT_ADDR = (gi == 0) ? `LOW_COUNT_ADDR : `HIGH_COUNT_ADDR;
         localparam logic [7:0] RLD_ADDR = (gi == 0) ? `LOW_RELOAD_ADDR : `HIGH_RELOAD_ADDR;

         // Own clock, run and function per half
         assign hif[gi].tick = pick_tick(state_reg.clock_select[SEL_POS +: 2], div_tick,
                                         rtc_tick_in, rtc_pulse_in);
         assign hif[gi].run = state_reg.control[RUN_BIT];
         assign hif[gi].split = state_reg.control[`SPLIT_ENABLE_BIT];
         assign hif[gi].cap_mode = state_reg.control[CAP_BIT];
         assign hif[gi].cap_evt = cap_evt;
         assign hif[gi].count_wr = sfr_wr_in && (sfr_addr_in == CNT_ADDR);
         assign hif[gi].reload_wr = sfr_wr_in && (sfr_addr_in == RLD_ADDR);
         assign hif[gi].wdata = sfr_wdata_in[WIDTH-1:0];
         assign flag_set[gi] = hif[gi].flag_set;

         timer_half #(.WIDTH(WIDTH)) u_half (
            .clock_in(clock_in),
            .rst_n_in(rst_n_in),
            .bus(hif[gi])
         );
      end
   endgenerate

   // ==========================================================================
   // Software write mask for byte and bit writes to control
   always_comb begin
      wr_mask = 8'h00;
      wr_val = sfr_wdata_in;
      if (sfr_wr_in && sfr_addr_in == `TIMER_CONTROL_ADDR) begin
         wr_mask = 8'hFF;
      end else if (sfr_bit_wr_in && sfr_addr_in == `TIMER_CONTROL_ADDR) begin
         wr_mask = 8'h01 << sfr_bit_sel_in;
         wr_val = {8{sfr_wdata_in[0]}};
      end
   end

   // Next state of the core
   always_comb begin
      state_next = state_reg;
      state_next.pin_meta = capture_pin_in;
      state_next.pin_sync = state_reg.pin_meta;
      state_next.pin_prev = state_reg.pin_sync;
      state_next.div_count = div_tick ? 4'h0 : state_reg.div_count + 4'h1;
      // Software writes first, then hardware sets win
      state_next.control = (state_reg.control & ~wr_mask) | (wr_val & wr_mask);
      if (flag_set[0]) begin
         state_next.control[`LOW_HALF_FLAG_BIT] = 1'b1;
      end
      if (flag_set[1]) begin
         state_next.control[`HIGH_HALF_FLAG_BIT] = 1'b1;
      end
      if (sfr_wr_in && sfr_addr_in == `TIMER_CLOCK_SELECT_ADDR) begin
         state_next.clock_select = sfr_wdata_in;
      end
      state_next.third_select = state_next.clock_select[`THIRD_LOW_CLOCK_SELECT_POS +: 4];
      // Single request from both flags
      state_next.irq = state_next.control[`HIGH_HALF_FLAG_BIT] ||
                       (state_next.control[`LOW_HALF_FLAG_BIT] &&
                        state_next.control[`LOW_HALF_IRQ_ENABLE_BIT]);
      state_next.capture_irq = cap_evt;
      if (sfr_rd_in) begin
         unique case (sfr_addr_in)
            `TIMER_CONTROL_ADDR: state_next.rdata = state_reg.control;
            `TIMER_CLOCK_SELECT_ADDR: state_next.rdata = state_reg.clock_select;
            `LOW_RELOAD_ADDR: state_next.rdata = 8'(hif[0].reload);
            `HIGH_RELOAD_ADDR: state_next.rdata = 8'(hif[1].reload);
            `LOW_COUNT_ADDR: state_next.rdata = 8'(hif[0].count);
            `HIGH_COUNT_ADDR: state_next.rdata = 8'(hif[1].count);
            default: state_next.rdata = 8'h00;
         endcase
      end
   end

   // State register
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= '{control: `TIMER_CONTROL_RESET,
                        clock_select: `TIMER_CLOCK_SELECT_RESET,
                        default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops
   assign sfr_rdata_out = state_reg.rdata;
   assign timer_irq_out = state_reg.irq;
   assign capture_irq_out = state_reg.capture_irq;
   assign third_clock_select_out = state_reg.third_select;

   // ==========================================================================
   // Checks
   logic ctrl_wr;
   assign ctrl_wr = (sfr_wr_in || sfr_bit_wr_in) && sfr_addr_in == `TIMER_CONTROL_ADDR;

   property p_both_capture_flags;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[4] && state_reg.control[3] && state_reg.control[2] && cap_evt)
         |=> (state_reg.control[7] && state_reg.control[6]);
   endproperty
   a_both_capture_flags: assert property (p_both_capture_flags)
      else $error("Shared capture did not set both flags");

   property p_irq_combine;
      @(posedge clock_in) disable iff (!rst_n_in)
      timer_irq_out == (state_reg.control[7] || (state_reg.control[6] && state_reg.control[5]));
   endproperty
   a_irq_combine: assert property (p_irq_combine)
      else $error("Interrupt request does not match flags");

   property p_flag_sticky;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[7] && !ctrl_wr) |=> state_reg.control[7];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("High flag cleared without a write");

   property p_timer_reload;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[4] && !state_reg.control[2] && hif[0].flag_set && !hif[0].count_wr)
         |=> hif[0].count == $past(hif[0].reload);
   endproperty
   a_timer_reload: assert property (p_timer_reload)
      else $error("Low timer half did not reload on wrap");

   property p_capture_copy;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[4] && state_reg.control[3] && cap_evt)
         |=> hif[1].reload == $past(hif[1].count);
   endproperty
   a_capture_copy: assert property (p_capture_copy)
      else $error("High capture half did not latch its count");

   property p_capture_stopped;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[4] && state_reg.control[2] && !state_reg.control[0] && cap_evt &&
       !hif[0].count_wr)
         |=> state_reg.control[6] && $stable(hif[0].count);
   endproperty
   a_capture_stopped: assert property (p_capture_stopped)
      else $error("Stopped capture half missed its capture");

   property p_timer_hold;
      @(posedge clock_in) disable iff (!rst_n_in)
      (!state_reg.control[2] && !state_reg.control[0] && !hif[0].count_wr)
         |=> $stable(hif[0].count) && !$past(hif[0].flag_set);
   endproperty
   a_timer_hold: assert property (p_timer_hold)
      else $error("Stopped timer half moved or flagged");

   property p_free_wrap;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[4] && state_reg.control[2] && state_reg.control[0] &&
       hif[0].tick && hif[0].count == 8'hFF && !hif[0].count_wr)
         |=> hif[0].count == 8'h00;
   endproperty
   a_free_wrap: assert property (p_free_wrap)
      else $error("Capture half did not wrap to zero");

   property p_div12;
      @(posedge clock_in) disable iff (!rst_n_in)
      div_tick |=> !div_tick [*8] ##1 !div_tick [*3] ##1 div_tick;
   endproperty
   a_div12: assert property (p_div12)
      else $error("System clock divide by twelve strobe off");

   property p_capture_irq;
      @(posedge clock_in) disable iff (!rst_n_in)
      cap_evt |=> capture_irq_out;
   endproperty
   a_capture_irq: assert property (p_capture_irq)
      else $error("Capture event lost its external interrupt pulse");

   property p_high_timer_reload;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[4] && !state_reg.control[3] && hif[1].flag_set && !hif[1].count_wr)
         |=> hif[1].count == $past(hif[1].reload);
   endproperty
   a_high_timer_reload: assert property (p_high_timer_reload)
      else $error("High timer half did not reload");

   property p_low_timer_flag;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[4] && !state_reg.control[2] && state_reg.control[0] &&
       hif[0].tick && hif[0].count == 8'hFF)
         |=> state_reg.control[6];
   endproperty
   a_low_timer_flag: assert property (p_low_timer_flag)
      else $error("Low overflow left flag clear");

   property p_both_timer_high_flag;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[4] && !state_reg.control[3] && !state_reg.control[2] &&
       state_reg.control[1] && hif[1].tick && hif[1].count == 8'hFF)
         |=> state_reg.control[7];
   endproperty
   a_both_timer_high_flag: assert property (p_both_timer_high_flag)
      else $error("High overflow left flag clear");

   property p_high_free_wrap;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[4] && state_reg.control[3] && state_reg.control[1] &&
       hif[1].tick && hif[1].count == 8'hFF && !hif[1].count_wr)
         |=> hif[1].count == 8'h00;
   endproperty
   a_high_free_wrap: assert property (p_high_free_wrap)
      else $error("High capture half did not wrap");

   property p_low_capture_copy;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[4] && state_reg.control[2] && cap_evt)
         |=> hif[0].reload == $past(hif[0].count);
   endproperty
   a_low_capture_copy: assert property (p_low_capture_copy)
      else $error("Low capture half did not latch");

   property p_high_capture_stopped;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_reg.control[4] && state_reg.control[3] && !state_reg.control[1] && cap_evt &&
       !hif[1].count_wr)
         |=> state_reg.control[7] && $stable(hif[1].count);
   endproperty
   a_high_capture_stopped: assert property (p_high_capture_stopped)
      else $error("Stopped high half missed capture");

   property p_high_timer_hold;
      @(posedge clock_in) disable iff (!rst_n_in)
      (!state_reg.control[3] && !state_reg.control[1] && !hif[1].count_wr)
         |=> $stable(hif[1].count) && !$past(hif[1].flag_set);
   endproperty
   a_high_timer_hold: assert property (p_high_timer_hold)
      else $error("Stopped high timer moved or flagged");

   property p_select_write;
      @(posedge clock_in) disable iff (!rst_n_in)
      (sfr_wr_in && sfr_addr_in == `TIMER_CLOCK_SELECT_ADDR)
         |=> third_clock_select_out == $past(sfr_wdata_in[7:4]);
   endproperty
   a_select_write: assert property (p_select_write)
      else $error("Third select output missed write");

   property p_bit_write;
      @(posedge clock_in) disable iff (!rst_n_in)
      (sfr_bit_wr_in && !sfr_wr_in && sfr_addr_in == `TIMER_CONTROL_ADDR && flag_set == 2'b00)
         |=> state_reg.control[$past(sfr_bit_sel_in)] == $past(sfr_wdata_in[0]);
   endproperty
   a_bit_write: assert property (p_bit_write)
      else $error("Bit write did not land");

endmodule // split_timer

/* verification/split_timer_bench.sv */
// Purpose: Self-checking bench for the split dual byte timer with capture.
// Assumes: Inputs change at the falling edge; the design samples at the rising edge.
// Notes: An integer model predicts counts, reloads, flags and interrupt levels.
`timescale 1ns/1ps
`include "split_timer_map.svh"

module split_dual_byte_timer_capture_bench;
   // ==========================================================================
   // Stimulus and observation signals
   logic clock_in, rst_n_in, sfr_wr_in, sfr_bit_wr_in, sfr_rd_in;
   logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
   logic [2:0] sfr_bit_sel_in;
   logic capture_pin_in, rtc_tick_in, rtc_pulse_in, timer_irq_out, capture_irq_out;
   logic [1:0] capture_edge_in;
   logic [3:0] third_clock_select_out;
   int fail_count, checked, nt, np, n;
   logic [31:0] seed, r;
   logic [7:0] d, ctl, cs, lc, hc, lr, hr, nc;
   logic [8:0] lo, hi;
   logic fh, fl, ev;
   localparam logic [7:0] ctl_addr = `TIMER_CONTROL_ADDR;
   localparam logic [7:0] sel_addr = `TIMER_CLOCK_SELECT_ADDR;
   localparam logic [7:0] lrl_addr = `LOW_RELOAD_ADDR;
   localparam logic [7:0] hrl_addr = `HIGH_RELOAD_ADDR;
   localparam logic [7:0] lcn_addr = `LOW_COUNT_ADDR;
   localparam logic [7:0] hcn_addr = `HIGH_COUNT_ADDR;

   // Device under test
   split_timer u_split_timer (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in),
      .sfr_wr_in(sfr_wr_in), .sfr_bit_wr_in(sfr_bit_wr_in), .sfr_bit_sel_in(sfr_bit_sel_in),
      .sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in), .capture_pin_in(capture_pin_in),
      .capture_edge_in(capture_edge_in), .rtc_tick_in(rtc_tick_in),
      .rtc_pulse_in(rtc_pulse_in), .sfr_rdata_out(sfr_rdata_out),
      .timer_irq_out(timer_irq_out), .capture_irq_out(capture_irq_out),
      .third_clock_select_out(third_clock_select_out));

   // ==========================================================================
   // Helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Model of one half over n ticks: overflow bit and new count
   function automatic logic [8:0] adv(input logic [7:0] c, input logic [7:0] rl,
                                      input int k, input logic cap);
      logic ovf;
      ovf = 1'h0;
      for (int i = 0; i < k; i++) begin
         if (c == 8'hFF) begin
            ovf = 1'h1;
            c = cap ? 8'h00 : rl;
         end else begin
            c = c + 8'h01;
         end
      end
      return {ovf, c};
   endfunction

   task automatic idle(input int k);
      repeat (k) @(negedge clock_in);
   endtask

   // Bus cycles: one strobe cycle, then one quiet cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      sfr_addr_in = a;
      sfr_wdata_in = v;
      sfr_wr_in = 1'h1;
      @(negedge clock_in);
      sfr_wr_in = 1'h0;
      @(negedge clock_in);
   endtask

   task automatic bw(input logic [2:0] s, input logic v);
      sfr_addr_in = ctl_addr;
      sfr_bit_sel_in = s;
      sfr_wdata_in = {7'h00, v};
      sfr_bit_wr_in = 1'h1;
      @(negedge clock_in);
      sfr_bit_wr_in = 1'h0;
      @(negedge clock_in);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      sfr_addr_in = a;
      sfr_rd_in = 1'h1;
      @(negedge clock_in);
      sfr_rd_in = 1'h0;
      v = sfr_rdata_out;
      @(negedge clock_in);
   endtask

   task automatic tally_and_finish();
      if (fail_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ==========================================================================
   // Clock and watchdog
   initial begin
      clock_in = 1'h0;
      forever #12.5 clock_in = ~clock_in;
   end

   initial begin
      #500000;
      fail_count++;
      tally_and_finish();
   end

   // ==========================================================================
   // Main sequence
   initial begin
      {rst_n_in, sfr_wr_in, sfr_bit_wr_in, sfr_rd_in, capture_pin_in} = 5'h00;
      {rtc_tick_in, rtc_pulse_in, capture_edge_in, sfr_bit_sel_in} = 7'h00;
      sfr_addr_in = 8'h00;
      sfr_wdata_in = 8'h00;
      fail_count = 0;
      checked = 0;
      seed = 32'h2E999512;
      repeat (5) @(negedge clock_in);
      rst_n_in = 1'h1;
      // Reset values and an unmapped read
      rd(ctl_addr, d); check(d, `TIMER_CONTROL_RESET);
      rd(sel_addr, d); check(d, `TIMER_CLOCK_SELECT_RESET);
      check({4'h0, third_clock_select_out}, 8'h00);
      rd(8'hD0, d); check(d, 8'h00);
      // Tick and pulse clocked halves, all function mixes
      for (int it = 0; it < 4; it++) begin
         r = rnd();
         cs = {r[7:4], 4'hE};
         wr(sel_addr, cs);
         rd(sel_addr, d); check(d, cs);
         check({4'h0, third_clock_select_out}, {4'h0, cs[7:4]});
         lc = 8'hF0 | {4'h0, r[11:8]};
         hc = 8'hF8 | {5'h00, r[14:12]};
         lr = r[23:16];
         hr = r[31:24];
         wr(lcn_addr, lc); wr(hcn_addr, hc); wr(lrl_addr, lr); wr(hrl_addr, hr);
         ctl = {2'h0, r[15], 1'h1, it[1], it[0], 2'h3};
         wr(ctl_addr, ctl);
         nt = 0;
         np = 0;
         repeat (30) begin
            r = rnd();
            rtc_tick_in = r[0];
            rtc_pulse_in = r[1];
            nt += int'(r[0]);
            np += int'(r[1]);
            @(negedge clock_in);
         end
         rtc_tick_in = 1'h0;
         rtc_pulse_in = 1'h0;
         idle(1);
         lo = adv(lc, lr, nt, it[0]);
         hi = adv(hc, hr, np, it[1]);
         fl = lo[8] & ~it[0];
         fh = hi[8] & ~it[1];
         rd(lcn_addr, d); check(d, lo[7:0]);
         rd(hcn_addr, d); check(d, hi[7:0]);
         rd(ctl_addr, d); check(d, {fh, fl, ctl[5:0]});
         check({7'h00, timer_irq_out}, {7'h00, fh | (fl & ctl[5])});
      end
      // System clock and divided clock on the low half only
      for (int s = 0; s < 2; s++) begin
         r = rnd();
         wr(ctl_addr, 8'h10);
         wr(sel_addr, {6'h00, s[1:0]});
         wr(lcn_addr, 8'hF0); wr(lrl_addr, 8'h20); wr(hcn_addr, 8'hFF);
         n = s == 1 ? 24 : 2 + int'(r[4:0]);
         bw(3'h0, 1'h1);
         idle(n - 2);
         bw(3'h0, 1'h0);
         lo = adv(8'hF0, 8'h20, s == 1 ? 2 : n, 1'h0);
         rd(lcn_addr, d); check(d, lo[7:0]);
         rd(hcn_addr, d); check(d, 8'hFF);
         rd(ctl_addr, d); check(d, {1'h0, lo[8], 6'h10});
      end
      // Flag clearing by bit writes and the combined request
      wr(ctl_addr, 8'hF0);
      check({7'h00, timer_irq_out}, 8'h01);
      bw(3'h5, 1'h0); idle(1); check({7'h00, timer_irq_out}, 8'h01);
      bw(3'h7, 1'h0); idle(1); check({7'h00, timer_irq_out}, 8'h00);
      bw(3'h5, 1'h1); idle(1); check({7'h00, timer_irq_out}, 8'h01);
      bw(3'h6, 1'h0); idle(1); check({7'h00, timer_irq_out}, 8'h00);
      // Captures under every edge mode and capture enable mix
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            r = rnd();
            capture_edge_in = m[1:0];
            wr(lrl_addr, 8'h00); wr(hrl_addr, 8'h00);
            wr(lcn_addr, r[7:0]); wr(hcn_addr, r[15:8]);
            ctl = {2'h0, r[18], 1'h1, 2'(m + p), 2'h0};
            wr(ctl_addr, ctl);
            capture_pin_in = ~capture_pin_in;
            ev = (m == 2) || (m == 0 && capture_pin_in) || (m == 1 && !capture_pin_in);
            nc = 8'h00;
            repeat (6) begin
               @(negedge clock_in);
               if (capture_irq_out === 1'h1) nc++;
            end
            check(nc, {7'h00, ev});
            rd(lrl_addr, d); check(d, (ev && ctl[2]) ? r[7:0] : 8'h00);
            rd(hrl_addr, d); check(d, (ev && ctl[3]) ? r[15:8] : 8'h00);
            rd(ctl_addr, d); check(d, {ev & ctl[3], ev & ctl[2], ctl[5:0]});
            rd(lcn_addr, d); check(d, r[7:0]);
         end
      end
      tally_and_finish();
   end
endmodule // split_dual_byte_timer_capture_bench
